// File: design/spims_defs.vh
// What this block does
// - Master: data write starts eight-bit transfer with generated clock, then done flag.
// - Master, select input low, not ignored: drop master role, become slave, set done.
// - Select ignore set in master: select pin has no effect at all.
// - Select pin as output in master: its level does not affect operation.
// - Normal mode: write during transfer is dropped and sets write-collision flag.
// - Normal mode: received byte goes to first receive buffer; read before next.
// - Normal mode: transmit buffer and second receive buffer unused.
// - Normal mode: transfer end sets done flag; interrupt when its enable set.
// - Buffer mode via buffer-enable; wait-for-receive ignored while master.
// - Buffer mode: write only when buffer empty; first sent, next held.
// - Buffer mode: received bytes enter two-entry receive FIFO.
// - Buffer mode: complete flag when shifter and transmit buffer empty; interrupt.
// - Slave selected: shift data out on incoming clock if data-out is output.
// - Slave deselected: no receive, output-configured data-out tri-stated.
// - Keep running in debug, freeze while processor halted by debugger.
// - Slave: select rising resets state machine, byte in progress lost.
// - Data write loads shifter in normal mode; in buffer mode, shifter for idle master or deselected waiting slave, else transmit buffer.
// - Buffer-empty flag clears on buffer write, sets when buffer moves to shifter.
// - Two-bit data mode picks clock polarity and phase; opposite edges.
`ifndef SPIMS_DEFS_VH
`define SPIMS_DEFS_VH
`define SPIMS_BITS 4'h8
`define SPIMS_DIV_W 8
`define SPIMS_ST_IDLE 2'h0
`define SPIMS_ST_RUN 2'h1
`endif

// File: design/spims_port.v
`timescale 1ns/1ps
`default_nettype none
`include "spims_defs.vh"
module spims_port #(
	parameter DIV_W = `SPIMS_DIV_W
) (
	input wire clk,
	input wire rst_n,
	input wire enable,
	input wire masterSet,
	input wire [DIV_W-1:0] sckHalfPeriod,
	input wire [1:0] dataMode,
	input wire bit_order_sel,
	input wire buffered_operation_on,
	input wire wait_for_receive_sel,
	input wire select_pin_ignore,
	input wire selDirOut,
	input wire misoDirOut,
	input wire debugHalt,
	input wire xfer_done_irq_on,
	input wire tx_complete_irq_on,
	input wire dataWr,
	input wire [7:0] dataIn,
	input wire dataRd,
	input wire flagClr,
	input wire sckIn,
	input wire mosiIn,
	input wire misoIn,
	input wire selIn_n,
	output reg masterRole,
	output reg [7:0] dataOut,
	output reg rxValid,
	output reg xferDone,
	output reg write_collision_flag,
	output reg tx_buffer_empty_flag,
	output reg tx_complete_flag,
	output reg irq,
	output reg sckOut,
	output reg mosiOut,
	output reg misoOut,
	output reg misoOe
);
	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	reg [2:0] sckS, mosiS, misoS, selS;
	always @(posedge clk) begin
		if (!rst_n) begin
			sckS <= 3'h0;
			mosiS <= 3'h0;
			misoS <= 3'h0;
			selS <= 3'h7;
		end else begin
			sckS <= {sckS[1:0], sckIn};
			mosiS <= {mosiS[1:0], mosiIn};
			misoS <= {misoS[1:0], misoIn};
			selS <= {selS[1:0], selIn_n};
		end
	end
	// a change counts only when stages two and three agree
	reg sckF_r, mosiF_r, misoF_r, selF_r;
	always @(posedge clk) begin
		if (!rst_n) begin
			sckF_r <= 1'b0;
			mosiF_r <= 1'b0;
			misoF_r <= 1'b0;
			selF_r <= 1'b1;
		end else begin
			if (sckS[1] == sckS[2])
				sckF_r <= sckS[2];
			if (mosiS[1] == mosiS[2])
				mosiF_r <= mosiS[2];
			if (misoS[1] == misoS[2])
				misoF_r <= misoS[2];
			if (selS[1] == selS[2])
				selF_r <= selS[2];
		end
	end
	reg sckPrev_r;
	// ----------------------------------------
	// transfer engine
	// ----------------------------------------
	reg [1:0] state_r;
	reg [7:0] shift_r;
	reg [3:0] bitCnt_r;
	reg [DIV_W-1:0] divCnt_r;
	reg phase_r;
	reg [7:0] txBuf_r;
	reg txBufFull_r;
	reg [7:0] rxFifo_r [0:1];
	reg [1:0] rxCnt_r;
	reg sampleBit_r;
	wire cpol = dataMode[1];
	wire cpha = dataMode[0];
	wire run = enable && !debugHalt;
	// in master, select only acts when input and not ignored
	wire selActive = !select_pin_ignore && !selDirOut;
	wire selected = !selF_r;
	wire slaveMode = !masterRole;
	wire sckRise = sckF_r && !sckPrev_r;
	wire sckFall = !sckF_r && sckPrev_r;
	// leading edge samples when phase clear, else trailing
	wire leadEdge = cpol ? sckFall : sckRise;
	wire trailEdge = cpol ? sckRise : sckFall;
	wire sEdge = cpha ? trailEdge : leadEdge;
	wire oEdge = cpha ? leadEdge : trailEdge;
	wire busy = state_r == `SPIMS_ST_RUN;
	// no shift before the first sample or after the last one
	wire midByte = bitCnt_r != 4'h0 && bitCnt_r != `SPIMS_BITS;
	// master ends only after the closing edge of its eighth clock
	wire byteEnd = bitCnt_r == `SPIMS_BITS &&
		(slaveMode || (divCnt_r == {DIV_W{1'b0}} && !phase_r));
	wire popRx = dataRd && rxCnt_r != 2'h0;
	wire [1:0] rxLeft = rxCnt_r - {1'b0, popRx};
	wire inBit = slaveMode ? mosiF_r : misoF_r;
	// bit order shared by both directions
	wire outBit = bit_order_sel ? shift_r[0] : shift_r[7];
	function [7:0] shiftIn;
		input [7:0] v;
		input lsbFirst;
		input b;
		shiftIn = lsbFirst ? {b, v[7:1]} : {v[6:0], b};
	endfunction
	wire [7:0] rdHead = rxFifo_r[0];
	integer i;
	always @(posedge clk) begin
		if (!rst_n) begin
			state_r <= `SPIMS_ST_IDLE;
			shift_r <= 8'h00;
			bitCnt_r <= 4'h0;
			divCnt_r <= {DIV_W{1'b0}};
			phase_r <= 1'b0;
			txBuf_r <= 8'h00;
			txBufFull_r <= 1'b0;
			for (i = 0; i < 2; i = i + 1)
				rxFifo_r[i] <= 8'h00;
			rxCnt_r <= 2'h0;
			sampleBit_r <= 1'b0;
			sckPrev_r <= 1'b0;
			masterRole <= 1'b0;
			xferDone <= 1'b0;
			write_collision_flag <= 1'b0;
			tx_buffer_empty_flag <= 1'b1;
			tx_complete_flag <= 1'b0;
		end else if (run) begin
			sckPrev_r <= sckF_r;
			if (flagClr) begin
				xferDone <= 1'b0;
				write_collision_flag <= 1'b0;
				tx_complete_flag <= 1'b0;
			end
			if (masterSet)
				masterRole <= 1'b1;
			// read pops the fifo head
			if (popRx) begin
				rxFifo_r[0] <= rxFifo_r[1];
				rxCnt_r <= rxCnt_r - 2'h1;
			end
			if (dataWr) begin
				if (!buffered_operation_on) begin
					if (busy)
						write_collision_flag <= 1'b1;
					else begin
						shift_r <= dataIn;
						if (masterRole) begin
							state_r <= `SPIMS_ST_RUN;
							bitCnt_r <= 4'h0;
							divCnt_r <= {DIV_W{1'b0}};
							phase_r <= 1'b0;
						end
					end
				end else if (tx_buffer_empty_flag) begin
					// idle master sends first byte at once
					if (!busy && masterRole) begin
						shift_r <= dataIn;
						state_r <= `SPIMS_ST_RUN;
						bitCnt_r <= 4'h0;
						divCnt_r <= {DIV_W{1'b0}};
						phase_r <= 1'b0;
					end else if (!busy && wait_for_receive_sel && !selected) begin
						shift_r <= dataIn;
					end else begin
						txBuf_r <= dataIn;
						txBufFull_r <= 1'b1;
						tx_buffer_empty_flag <= 1'b0;
					end
				end
			end
			if (masterRole && selActive && selected) begin
				masterRole <= 1'b0;
				xferDone <= 1'b1;
				state_r <= `SPIMS_ST_IDLE;
				bitCnt_r <= 4'h0;
			end else if (masterRole && busy) begin
				if (divCnt_r == sckHalfPeriod) begin
					divCnt_r <= {DIV_W{1'b0}};
					phase_r <= !phase_r;
					// miso comes through the pin synchroniser: keep
					// half-periods above five clocks or bits arrive late
					if (phase_r == cpha) begin
						sampleBit_r <= inBit;
						bitCnt_r <= bitCnt_r + 4'h1;
					end else if (midByte)
						shift_r <= shiftIn(shift_r, bit_order_sel, sampleBit_r);
				end else
					divCnt_r <= divCnt_r + {{(DIV_W-1){1'b0}}, 1'b1};
			end else if (slaveMode && !selected) begin
				// deselect resets and loses partial byte
				state_r <= `SPIMS_ST_IDLE;
				bitCnt_r <= 4'h0;
			end else if (slaveMode) begin
				state_r <= `SPIMS_ST_RUN;
				if (sEdge)
					sampleBit_r <= inBit;
				if (oEdge && midByte)
					shift_r <= shiftIn(shift_r, bit_order_sel, sampleBit_r);
				if (sEdge)
					bitCnt_r <= bitCnt_r + 4'h1;
			end
			// end of byte
			if (byteEnd) begin
				bitCnt_r <= 4'h0;
				state_r <= slaveMode ? `SPIMS_ST_RUN : `SPIMS_ST_IDLE;
				xferDone <= 1'b1;
				if (!buffered_operation_on) begin
					// single receive buffer in normal mode
					rxFifo_r[0] <= shiftIn(shift_r, bit_order_sel, sampleBit_r);
					rxCnt_r <= 2'h1;
					shift_r <= shiftIn(shift_r, bit_order_sel, sampleBit_r);
				end else begin
					// two-entry receive fifo, oldest kept on overflow
					// a read in the same cycle frees its slot first
					if (rxLeft != 2'h2)
						rxFifo_r[rxLeft[0]] <= shiftIn(shift_r,
							bit_order_sel, sampleBit_r);
					if (rxLeft != 2'h2)
						rxCnt_r <= rxLeft + 2'h1;
					if (txBufFull_r) begin
						shift_r <= txBuf_r;
						txBufFull_r <= 1'b0;
						tx_buffer_empty_flag <= 1'b1;
						if (masterRole)
							state_r <= `SPIMS_ST_RUN;
					end else begin
						shift_r <= shiftIn(shift_r, bit_order_sel, sampleBit_r);
						tx_complete_flag <= 1'b1;
					end
				end
			end
		end
	end
	// ----------------------------------------
	// registered outputs
	// ----------------------------------------
	always @(posedge clk) begin
		if (!rst_n) begin
			dataOut <= 8'h00;
			rxValid <= 1'b0;
			irq <= 1'b0;
			sckOut <= 1'b0;
			mosiOut <= 1'b0;
			misoOut <= 1'b0;
			misoOe <= 1'b0;
		end else begin
			dataOut <= rdHead;
			rxValid <= rxCnt_r != 2'h0;
			irq <= (xfer_done_irq_on && xferDone) ||
				(tx_complete_irq_on && tx_complete_flag);
			// idle clock sits at polarity level
			sckOut <= cpol ^ (masterRole && busy && phase_r);
			mosiOut <= masterRole ? outBit : 1'b0;
			misoOut <= outBit;
			misoOe <= enable && slaveMode && misoDirOut && selected;
		end
	end
endmodule // spims_port
`default_nettype wire

// File: tb/spims_checker.sv
`timescale 1ns/1ps
`default_nettype none
module spims_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic select_pin_ignore,
	input wire logic selDirOut,
	input wire logic selIn_n,
	input wire logic dataWr,
	input wire logic debugHalt,
	input wire logic xfer_done_irq_on,
	input wire logic misoDirOut,
	input wire logic masterRole,
	input wire logic xferDone,
	input wire logic write_collision_flag,
	input wire logic tx_buffer_empty_flag,
	input wire logic irq,
	input wire logic sckOut,
	input wire logic misoOe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ----------------------------------------
	// select held high past the synchroniser
	// ----------------------------------------
	sequence selHeld;
		selIn_n [*6];
	endsequence
	role_drop_a: assert property ($fell(masterRole) |-> ##[0:2] xferDone)
		else $error("role lost without done flag");
	keep_master_a: assert property ((masterRole && select_pin_ignore) [*5] |=> masterRole)
		else $error("ignored select changed role");
	pin_out_a: assert property ((masterRole && selDirOut) [*5] |=> masterRole)
		else $error("output select changed role");
	coll_cause_a: assert property ($rose(write_collision_flag) |-> $past(dataWr) || $past(dataWr, 2))
		else $error("collision without write");
	irq_done_a: assert property ($rose(xferDone) && xfer_done_irq_on |-> ##[0:2] irq)
		else $error("done without irq");
	miso_deselect_a: assert property (selHeld |-> !misoOe)
		else $error("data-out driven while deselected");
	miso_dir_a: assert property (misoOe |->
		$past(!masterRole && misoDirOut))
		else $error("data-out driven when not allowed");
	freeze_a: assert property (debugHalt [*3] |-> $stable(sckOut))
		else $error("clock moved while halted");
	empty_fall_a: assert property ($fell(tx_buffer_empty_flag) |-> $past(dataWr) || $past(dataWr, 2))
		else $error("empty flag fell without write");
endmodule // spims_checker
bind spims_port spims_checker u_chk (.clk(clk), .rst_n(rst_n),
	.select_pin_ignore(select_pin_ignore), .selDirOut(selDirOut),
	.selIn_n(selIn_n), .dataWr(dataWr), .debugHalt(debugHalt),
	.xfer_done_irq_on(xfer_done_irq_on), .misoDirOut(misoDirOut),
	.masterRole(masterRole), .xferDone(xferDone), .irq(irq),
	.write_collision_flag(write_collision_flag), .sckOut(sckOut),
	.tx_buffer_empty_flag(tx_buffer_empty_flag), .misoOe(misoOe));
`default_nettype wire

// File: tb/spims_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module spims_far_end (
	input wire logic sckOut,
	input wire logic mosiOut,
	input wire logic misoOut,
	output logic sckIn,
	output logic mosiIn,
	output wire logic misoIn,
	output logic selIn_n
);
	logic [7:0] sTx = 8'hC1;
	logic [7:0] sRx = 8'h00;
	assign misoIn = sTx[7];
	always @(posedge sckOut) sRx <= {sRx[6:0], mosiOut};
	// rotate so the pattern repeats every byte
	always @(negedge sckOut) sTx <= {sTx[6:0], sTx[7]};
	initial begin
		sckIn = 1'b0;
		mosiIn = 1'b0;
		selIn_n = 1'b1;
	end
	task automatic mstr(input logic [7:0] b, input int n, output logic [7:0] r);
		selIn_n = 1'b0;
		#80;
		for (int i = 0; i < n; i++) begin
			mosiIn = b[7 - i];
			#80 sckIn = 1'b1;
			r = {r[6:0], misoOut};
			#80 sckIn = 1'b0;
		end
		#80 selIn_n = 1'b1;
		mosiIn = ~mosiIn;
	endtask
endmodule // spims_far_end
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk, rst_n, masterSet, dataWr, dataRd, flagClr, debugHalt, enable;
	logic bit_order_sel, buffered_operation_on, wait_for_receive_sel;
	logic select_pin_ignore, selDirOut, misoDirOut;
	logic xfer_done_irq_on, tx_complete_irq_on;
	logic [7:0] dataIn, r;
	wire masterRole, rxValid, xferDone, write_collision_flag, irq;
	wire tx_buffer_empty_flag, tx_complete_flag, sckOut, mosiOut, misoOut;
	wire misoOe, sckIn, mosiIn, misoIn, selIn_n;
	wire [7:0] dataOut;
	int n_mismatch = 0;
	int samples_checked = 0;
	spims_port u_spims_port (.clk(clk), .rst_n(rst_n), .enable(enable),
		.masterSet(masterSet), .sckHalfPeriod(8'h07), .dataMode(2'h0),
		.bit_order_sel(bit_order_sel), .debugHalt(debugHalt),
		.buffered_operation_on(buffered_operation_on),
		.wait_for_receive_sel(wait_for_receive_sel),
		.select_pin_ignore(select_pin_ignore), .selDirOut(selDirOut),
		.misoDirOut(misoDirOut), .xfer_done_irq_on(xfer_done_irq_on),
		.tx_complete_irq_on(tx_complete_irq_on), .dataWr(dataWr),
		.dataIn(dataIn), .dataRd(dataRd), .flagClr(flagClr), .sckIn(sckIn),
		.mosiIn(mosiIn), .misoIn(misoIn), .selIn_n(selIn_n),
		.masterRole(masterRole), .dataOut(dataOut), .rxValid(rxValid),
		.xferDone(xferDone), .write_collision_flag(write_collision_flag),
		.tx_buffer_empty_flag(tx_buffer_empty_flag), .irq(irq),
		.tx_complete_flag(tx_complete_flag), .sckOut(sckOut),
		.mosiOut(mosiOut), .misoOut(misoOut), .misoOe(misoOe));
	spims_far_end u_far (.sckOut(sckOut), .mosiOut(mosiOut), .misoOut(misoOut),
		.sckIn(sckIn), .mosiIn(mosiIn), .misoIn(misoIn), .selIn_n(selIn_n));
	always #5 clk = ~clk;
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// k: 0 pops receive head, 1 clears flags, 2 claims master role
	task automatic strobe(input int k);
		{masterSet, flagClr, dataRd} = 3'h1 << k;
		tick(1);
		{masterSet, flagClr, dataRd} = 3'h0;
		tick(1);
	endtask
	task automatic wr(input logic [7:0] b);
		dataWr = 1'b1;
		dataIn = b;
		tick(1);
		dataWr = 1'b0;
		tick(1);
	endtask
	task automatic rd(input logic [7:0] e);
		chk(dataOut, e);
		strobe(0);
	endtask
	task automatic waitFlag(input bit tc);
		int i;
		for (i = 0; i < 3000 && (tc ? tx_complete_flag : xferDone) !== 1'b1; i++)
			tick(1);
		if (i == 3000) begin
			n_mismatch++;
			summarize();
		end
		tick(2);
	endtask
	task automatic summarize();
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		{clk, rst_n, masterSet, dataWr, dataRd, flagClr, debugHalt} = 7'h00;
		{bit_order_sel, buffered_operation_on, wait_for_receive_sel} = 3'h0;
		{select_pin_ignore, selDirOut, misoDirOut} = 3'h0;
		{xfer_done_irq_on, tx_complete_irq_on, dataIn} = 10'h000;
		enable = 1'b0;
		tick(3);
		rst_n = 1'b1;
		tick(4);
		chk({5'h00, masterRole, xferDone, tx_buffer_empty_flag}, 8'h01);
		strobe(2);
		chk({7'h00, masterRole}, 8'h00);
		enable = 1'b1;
		xfer_done_irq_on = 1'b1;
		strobe(2);
		wr(8'h3C);
		wr(8'h99);
		debugHalt = 1'b1;
		tick(40);
		debugHalt = 1'b0;
		waitFlag(0);
		chk({6'h00, write_collision_flag, irq}, 8'h03);
		chk(u_far.sRx, 8'h3C);
		rd(8'hC1);
		chk({7'h00, rxValid}, 8'h00);
		strobe(1);
		chk({7'h00, irq}, 8'h00);
		bit_order_sel = 1'b1;
		wr(8'h12);
		waitFlag(0);
		chk(u_far.sRx, 8'h48);
		rd(8'h83);
		{bit_order_sel, xfer_done_irq_on} = 2'h0;
		{buffered_operation_on, wait_for_receive_sel, tx_complete_irq_on} = 3'h7;
		strobe(1);
		wr(8'h43);
		wr(8'h44);
		chk({7'h00, tx_buffer_empty_flag}, 8'h00);
		wr(8'h45);
		waitFlag(1);
		chk({6'h00, irq, rxValid}, 8'h03);
		chk(u_far.sRx, 8'h44);
		rd(8'hC1);
		rd(8'hC1);
		chk({7'h00, rxValid}, 8'h00);
		buffered_operation_on = 1'b0;
		strobe(1);
		select_pin_ignore = 1'b1;
		u_far.selIn_n = 1'b0;
		tick(10);
		chk({7'h00, masterRole}, 8'h01);
		{select_pin_ignore, selDirOut} = 2'h1;
		tick(10);
		chk({7'h00, masterRole}, 8'h01);
		selDirOut = 1'b0;
		tick(10);
		chk({6'h00, masterRole, xferDone}, 8'h01);
		u_far.selIn_n = 1'b1;
		misoDirOut = 1'b1;
		strobe(1);
		u_far.mstr(8'hFF, 3, r);
		tick(6);
		chk({7'h00, xferDone}, 8'h00);
		wr(8'h5A);
		u_far.mstr(8'h96, 8, r);
		tick(6);
		chk(r, 8'h5A);
		chk({7'h00, misoOe}, 8'h00);
		rd(8'h96);
		strobe(2);
		chk({7'h00, masterRole}, 8'h01);
		summarize();
	end
endmodule // tb
`default_nettype wire
